// File: src/ecdma_dma_channels.sv
// two dma channels between usb endpoint buffers and the codec serial port
// assumes the buffer manager presents the selected endpoint's flags and pointers
// per channel, and a byte memory port whose read data is valid one cycle after mem_rd
`timescale 1ns/1ps
module ecdma_dma_channels #(
	parameter int AW = ecdma_pkg::ADDR_W,
	parameter int SLOT_BITS = ecdma_pkg::SLOT_BITS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// avalon-mm register slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// buffer manager, per channel, channel c in bits of slice c
	input wire logic sof,
	input wire logic [ecdma_pkg::NCH-1:0] ep_iso,
	input wire logic [ecdma_pkg::NCH-1:0] ep_dbuf,
	input wire logic [ecdma_pkg::NCH-1:0] ep_x_nack,
	input wire logic [ecdma_pkg::NCH-1:0] ep_y_nack,
	input wire logic [ecdma_pkg::NCH-1:0] ep_toggle,
	input wire logic [ecdma_pkg::NCH*AW-1:0] ep_x_base,
	input wire logic [ecdma_pkg::NCH*AW-1:0] ep_y_base,
	input wire logic [ecdma_pkg::NCH*AW-1:0] ep_size,
	input wire logic [ecdma_pkg::NCH*AW-1:0] ep_x_count,
	input wire logic [ecdma_pkg::NCH*AW-1:0] ep_y_count,
	input wire logic [ecdma_pkg::NCH*AW-1:0] ep_ring_ptr,
	output logic [ecdma_pkg::NCH*ecdma_pkg::EPN_W-1:0] chan_ep_num,
	output logic [ecdma_pkg::NCH-1:0] chan_ep_dir,
	output logic [ecdma_pkg::NCH-1:0] nack_clr_x,
	output logic [ecdma_pkg::NCH-1:0] nack_clr_y,
	output logic [ecdma_pkg::NCH*AW-1:0] ring_ptr,
	output logic chan0_done_irq,
	output logic chan1_done_irq,
	// endpoint buffer memory port
	output logic [AW-1:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// codec port pins
	input wire logic codec_clk,
	input wire logic codec_sync,
	input wire logic codec_din,
	output logic codec_dout,
	output logic codec_dout_oe
);
	localparam int NCH = ecdma_pkg::NCH;
	localparam int BW = $clog2(SLOT_BITS);

	// software settings
	logic [NCH-1:0] en;
	logic [NCH-1:0] hsk;
	logic [NCH-1:0] dir;
	logic [ecdma_pkg::EPN_W-1:0] epn [NCH];
	logic [ecdma_pkg::PCOUNT_W-1:0] pcnt [NCH];
	logic [ecdma_pkg::SLOTS-1:0] smask [NCH];
	logic [ecdma_pkg::BPS_W-1:0] bps [NCH];
	logic [AW-1:0] bcnt [NCH];
	// engine state
	ecdma_pkg::ecdma_state_t st [NCH];
	logic [AW-1:0] ptr [NCH];
	logic [AW-1:0] remain [NCH];
	logic [NCH-1:0] use_y;
	logic [NCH-1:0] done_irq;
	logic [NCH-1:0] out_valid;
	logic [NCH-1:0] fetch_pend;
	logic [NCH-1:0] in_valid;
	logic [7:0] out_byte [NCH];
	logic [7:0] in_byte [NCH];
	logic [7:0] in_sh [NCH];
	// codec side
	logic [2:0] pins_s;
	logic clk_d;
	logic crise;
	logic fstart;
	logic [3:0] slot_q;
	logic [BW-1:0] bit_q;
	logic [3:0] nslot;
	logic [BW-1:0] nbit;
	logic [7:0] out_sh;
	logic [7:0] out_load;
	logic out_any;
	// memory arbitration
	logic go;
	logic go_wr;
	logic sel;
	logic rd_owner;
	logic rd_back;
	// per channel decode
	logic [NCH-1:0] take_out;
	logic [NCH-1:0] take_in;
	logic [NCH-1:0] drained;
	logic [NCH-1:0] want_fetch;
	logic [NCH-1:0] finish;
	logic [NCH-1:0] x_full;
	logic [NCH-1:0] y_full;
	logic [NCH-1:0] grant_rd;
	logic [NCH-1:0] grant_wr;
	logic [AW-1:0] addr_of [NCH];
	logic [31:0] rd_word;
	logic wr_hit;

	// wrap a circular buffer offset at the size setting
	function automatic logic [AW-1:0] ring_next(input logic [AW-1:0] p,
		input logic [AW-1:0] size);
		logic [AW:0] s;
		s = {1'b0, p} + {{AW{1'b0}}, 1'b1};
		ring_next = (s >= {1'b0, size}) ? '0 : s[AW-1:0];
	endfunction : ring_next

	// bytes between the two pointers of a circular buffer
	function automatic logic [AW-1:0] ring_fill(input logic [AW-1:0] wp,
		input logic [AW-1:0] rp, input logic [AW-1:0] size);
		ring_fill = (wp >= rp) ? AW'(wp - rp) : AW'(wp + size - rp);
	endfunction : ring_fill

	// oldest full buffer; with both full the toggle names the next write target
	function automatic logic pick_y(input logic dbuf, input logic xn, input logic yn,
		input logic tog);
		if (!dbuf)
			pick_y = 1'b0;
		else if (xn && yn)
			pick_y = tog;
		else
			pick_y = yn;
	endfunction : pick_y

	// is this slot in a channel's mask
	function automatic logic slot_on(input logic [ecdma_pkg::SLOTS-1:0] mask,
		input logic [3:0] slot);
		slot_on = 1'b0;
		for (int i = 0; i < ecdma_pkg::SLOTS; i++)
			if (slot == 4'(i))
				slot_on = mask[i];
	endfunction : slot_on

	ecdma_sync #(
		.W(3)
	) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.d({codec_din, codec_sync, codec_clk}),
		.q(pins_s)
	);

	assign crise = pins_s[0] && !clk_d;
	assign fstart = crise && pins_s[1];
	assign wr_hit = avs_write && !avs_waitrequest;
	assign chan0_done_irq = done_irq[0];
	assign chan1_done_irq = done_irq[1];

	// codec bit position after this rising edge; slots past the last stay unserved
	always_comb
	begin
		if (pins_s[1])
		begin
			nslot = 4'h0;
			nbit = '0;
		end
		else if (bit_q == BW'(SLOT_BITS - 1))
		begin
			nslot = (slot_q == 4'hF) ? slot_q : slot_q + 4'h1;
			nbit = '0;
		end
		else
		begin
			nslot = slot_q;
			nbit = bit_q + {{(BW - 1){1'b0}}, 1'b1};
		end
	end

	// per channel decode of byte moves, drain and fetch needs
	always_comb
	begin
		logic served;
		logic blocked;
		served = 1'b0;
		blocked = 1'b0;
		out_load = 8'h00;
		out_any = 1'b0;
		for (int c = 0; c < NCH; c++)
		begin
			// a flag whose clear pulse is still out reads full one more cycle; never retake it
			x_full[c] = ep_x_nack[c] && !nack_clr_x[c];
			y_full[c] = ep_dbuf[c] && ep_y_nack[c] && !nack_clr_y[c];
			served = slot_on(smask[c], nslot) &&
				(ecdma_pkg::BPS_W'(nbit >> 3) < bps[c]);
			take_out[c] = crise && (nbit[2:0] == 3'h0) && served && !blocked &&
				st[c] == ecdma_pkg::ST_MOVE && !dir[c] && out_valid[c];
			if (take_out[c])
			begin
				blocked = 1'b1;
				out_any = 1'b1;
				out_load = out_byte[c];
			end
			take_in[c] = crise && (nbit[2:0] == 3'h7) && served &&
				st[c] == ecdma_pkg::ST_MOVE && dir[c];
			drained[c] = st[c] == ecdma_pkg::ST_MOVE && !ep_iso[c] && remain[c] == '0 &&
				!out_valid[c] && !fetch_pend[c];
			want_fetch[c] = st[c] == ecdma_pkg::ST_MOVE && !dir[c] && !out_valid[c] &&
				!fetch_pend[c] &&
				(ep_iso[c] ? ptr[c] != ep_ring_ptr[c*AW +: AW] : remain[c] != '0);
			addr_of[c] = ep_iso[c] ? AW'(ep_x_base[c*AW +: AW] + ptr[c]) : ptr[c];
			finish[c] = hsk[c] && !ep_iso[c] &&
				((drained[c] && pcnt[c] == ecdma_pkg::PCOUNT_W'(1)) ||
				(st[c] == ecdma_pkg::ST_IDLE && en[c] && !dir[c] && pcnt[c] == '0));
		end
	end

	// memory arbiter: byte writes before fetches, lower channel first
	always_comb
	begin
		go = 1'b0;
		go_wr = 1'b0;
		sel = 1'b0;
		for (int c = NCH - 1; c >= 0; c--)
			if (want_fetch[c])
			begin
				go = 1'b1;
				sel = 1'(c);
			end
		for (int c = NCH - 1; c >= 0; c--)
			if (in_valid[c])
			begin
				go = 1'b1;
				go_wr = 1'b1;
				sel = 1'(c);
			end
		for (int c = 0; c < NCH; c++)
		begin
			grant_rd[c] = go && !go_wr && sel == 1'(c);
			grant_wr[c] = go && go_wr && sel == 1'(c);
		end
	end

	// read word for the addressed channel register
	always_comb
	begin
		logic c;
		c = avs_address[ecdma_pkg::CH_SEL_BIT];
		rd_word = 32'h0000_0000;
		case (avs_address[4:0])
			ecdma_pkg::OFS_CTRL:
			begin
				rd_word[ecdma_pkg::CTRL_EN] = en[c];
				rd_word[ecdma_pkg::CTRL_HSK] = hsk[c];
				rd_word[ecdma_pkg::CTRL_DIR] = dir[c];
				rd_word[ecdma_pkg::CTRL_EPN +: ecdma_pkg::EPN_W] = epn[c];
				rd_word[ecdma_pkg::CTRL_STATE +: 4] = st[c];
			end
			ecdma_pkg::OFS_PCOUNT: rd_word[ecdma_pkg::PCOUNT_W-1:0] = pcnt[c];
			ecdma_pkg::OFS_SLOT:
			begin
				rd_word[ecdma_pkg::SLOT_MASK +: ecdma_pkg::SLOTS] = smask[c];
				rd_word[ecdma_pkg::SLOT_BPS +: ecdma_pkg::BPS_W] = bps[c];
			end
			ecdma_pkg::OFS_BCNT: rd_word[AW-1:0] = bcnt[c];
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// bus handshake: one wait cycle, then the answer; unmapped reads give zero
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= rd_word;
		end
	end

	// channel settings; software enable write wins over a hardware clear
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			en <= '0;
			hsk <= '0;
			dir <= '0;
			for (int c = 0; c < NCH; c++)
			begin
				epn[c] <= ecdma_pkg::EPN_RST;
				pcnt[c] <= ecdma_pkg::PCOUNT_RST;
				smask[c] <= ecdma_pkg::MASK_RST;
				bps[c] <= ecdma_pkg::BPS_RST;
			end
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (wr_hit && avs_address[ecdma_pkg::CH_SEL_BIT] == 1'(c) &&
					avs_address[4:0] == ecdma_pkg::OFS_CTRL)
				begin
					en[c] <= avs_writedata[ecdma_pkg::CTRL_EN];
					hsk[c] <= avs_writedata[ecdma_pkg::CTRL_HSK];
					dir[c] <= avs_writedata[ecdma_pkg::CTRL_DIR];
					epn[c] <= avs_writedata[ecdma_pkg::CTRL_EPN +: ecdma_pkg::EPN_W];
				end
				else if (finish[c])
					en[c] <= 1'b0;
				if (wr_hit && avs_address[ecdma_pkg::CH_SEL_BIT] == 1'(c) &&
					avs_address[4:0] == ecdma_pkg::OFS_PCOUNT)
					pcnt[c] <= avs_writedata[ecdma_pkg::PCOUNT_W-1:0];
				else if (drained[c] && hsk[c] && pcnt[c] != '0)
					pcnt[c] <= pcnt[c] - ecdma_pkg::PCOUNT_W'(1);
				if (wr_hit && avs_address[ecdma_pkg::CH_SEL_BIT] == 1'(c) &&
					avs_address[4:0] == ecdma_pkg::OFS_SLOT)
				begin
					smask[c] <= avs_writedata[ecdma_pkg::SLOT_MASK +: ecdma_pkg::SLOTS];
					bps[c] <= avs_writedata[ecdma_pkg::SLOT_BPS +: ecdma_pkg::BPS_W];
				end
			end
		end
	end

	// channel engines: buffer selection, drain completion, iso frame pacing
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			use_y <= '0;
			done_irq <= '0;
			nack_clr_x <= '0;
			nack_clr_y <= '0;
			for (int c = 0; c < NCH; c++)
			begin
				st[c] <= ecdma_pkg::ST_IDLE;
				ptr[c] <= '0;
				remain[c] <= '0;
			end
		end
		else
		begin
			done_irq <= '0;
			nack_clr_x <= '0;
			nack_clr_y <= '0;
			for (int c = 0; c < NCH; c++)
			begin
				if (!en[c])
					st[c] <= ecdma_pkg::ST_IDLE;
				else
				begin
					case (st[c])
						ecdma_pkg::ST_IDLE:
						begin
							if (ep_iso[c])
							begin
								// iso in or out, always through a channel
								ptr[c] <= '0;
								st[c] <= dir[c] ? ecdma_pkg::ST_MOVE : ecdma_pkg::ST_WSOF;
							end
							else if (dir[c])
								st[c] <= ecdma_pkg::ST_IDLE; // bulk in refused
							else if (finish[c])
								done_irq[c] <= 1'b1; // empty count completes at once
							else if (x_full[c] || y_full[c])
							begin
								// each stored packet re-arms this; endpoint irq is not ours
								use_y[c] <= pick_y(ep_dbuf[c], x_full[c], y_full[c], ep_toggle[c]);
								if (pick_y(ep_dbuf[c], x_full[c], y_full[c], ep_toggle[c]))
								begin
									ptr[c] <= ep_y_base[c*AW +: AW];
									remain[c] <= ep_y_count[c*AW +: AW]; // count left
								end
								else
								begin
									ptr[c] <= ep_x_base[c*AW +: AW];
									remain[c] <= ep_x_count[c*AW +: AW];
								end
								st[c] <= ecdma_pkg::ST_MOVE;
							end
						end
						ecdma_pkg::ST_MOVE:
						begin
							if (ep_iso[c] && !dir[c] && ptr[c] == ep_ring_ptr[c*AW +: AW] &&
								!out_valid[c] && !fetch_pend[c])
								st[c] <= ecdma_pkg::ST_WSOF; // caught up, hold for next sof
							else if (drained[c])
							begin
								nack_clr_x[c] <= !use_y[c];
								nack_clr_y[c] <= use_y[c];
								done_irq[c] <= finish[c];
								st[c] <= ecdma_pkg::ST_IDLE; // next packet
							end
						end
						ecdma_pkg::ST_WSOF:
							if (sof)
								st[c] <= ecdma_pkg::ST_WFRM;
						ecdma_pkg::ST_WFRM:
							if (fstart)
								st[c] <= ecdma_pkg::ST_MOVE;
						default: st[c] <= ecdma_pkg::ST_IDLE;
					endcase
				end
				if ((grant_rd[c] || grant_wr[c]) && st[c] == ecdma_pkg::ST_MOVE)
				begin
					if (ep_iso[c])
						ptr[c] <= ring_next(ptr[c], ep_size[c*AW +: AW]);
					else
					begin
						ptr[c] <= ptr[c] + {{(AW - 1){1'b0}}, 1'b1};
						remain[c] <= remain[c] - {{(AW - 1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end

	// one-byte holding stages; a new input byte wins over its write-out clear
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			out_valid <= '0;
			fetch_pend <= '0;
			in_valid <= '0;
			for (int c = 0; c < NCH; c++)
			begin
				out_byte[c] <= 8'h00;
				in_byte[c] <= 8'h00;
				in_sh[c] <= 8'h00;
			end
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (crise)
					in_sh[c] <= {in_sh[c][6:0], pins_s[2]};
				if (!en[c])
				begin
					out_valid[c] <= 1'b0;
					fetch_pend[c] <= 1'b0;
					in_valid[c] <= 1'b0;
				end
				else
				begin
					if (take_out[c])
						out_valid[c] <= 1'b0;
					if (grant_rd[c])
						fetch_pend[c] <= 1'b1;
					else if (rd_back && rd_owner == 1'(c) && fetch_pend[c])
					begin
						fetch_pend[c] <= 1'b0;
						out_valid[c] <= 1'b1;
						out_byte[c] <= mem_rdata;
					end
					if (take_in[c])
					begin
						in_valid[c] <= 1'b1;
						in_byte[c] <= {in_sh[c][6:0], pins_s[2]};
					end
					else if (grant_wr[c])
						in_valid[c] <= 1'b0;
				end
			end
		end
	end

	// memory port: one access per cycle, read data returns a cycle later
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			mem_addr <= '0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			rd_owner <= 1'b0;
			rd_back <= 1'b0;
		end
		else
		begin
			mem_rd <= go && !go_wr;
			mem_wr <= go && go_wr;
			mem_addr <= addr_of[sel];
			mem_wdata <= in_byte[sel];
			rd_owner <= sel;
			rd_back <= mem_rd;
		end
	end

	// codec framing and serial output; no data in a served slot leaves the pin undriven
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			clk_d <= 1'b0;
			slot_q <= 4'h0;
			bit_q <= '0;
			out_sh <= 8'h00;
			codec_dout_oe <= 1'b0;
		end
		else
		begin
			clk_d <= pins_s[0];
			if (crise)
			begin
				slot_q <= nslot;
				bit_q <= nbit;
				if (nbit[2:0] == 3'h0)
				begin
					out_sh <= out_any ? out_load : 8'h00;
					codec_dout_oe <= out_any;
				end
				else
					out_sh <= {out_sh[6:0], 1'b0};
			end
		end
	end

	assign codec_dout = out_sh[7];

	// frame byte count captured at each start of frame
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int c = 0; c < NCH; c++)
				bcnt[c] <= '0;
		end
		else if (sof)
		begin
			for (int c = 0; c < NCH; c++)
				bcnt[c] <= dir[c] ?
					ring_fill(ptr[c], ep_ring_ptr[c*AW +: AW], ep_size[c*AW +: AW]) :
					ring_fill(ep_ring_ptr[c*AW +: AW], ptr[c], ep_size[c*AW +: AW]);
		end
	end

	// endpoint selection and ring pointer reported to the buffer manager
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			chan_ep_num[c*ecdma_pkg::EPN_W +: ecdma_pkg::EPN_W] = epn[c];
			chan_ep_dir[c] = dir[c];
			ring_ptr[c*AW +: AW] = ptr[c];
		end
	end
endmodule : ecdma_dma_channels

// File: src/ecdma_pkg.sv
// shared constants for the two-channel endpoint-to-codec dma block
// assumes byte addressing on the register bus, 32-bit data, one word per register
package ecdma_pkg;

	// structure
	localparam int NCH = 2;
	localparam int ADDR_W = 11;
	localparam int SLOTS = 14;
	localparam int SLOT_BITS = 16;
	localparam int BYTE_W = 8;

	// register byte offsets inside a channel window, channel picked by one address bit
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_PCOUNT = 5'h04;
	localparam logic [4:0] OFS_SLOT = 5'h08;
	localparam logic [4:0] OFS_BCNT = 5'h0C;
	localparam int CH_SEL_BIT = 5;

	// control word fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_HSK = 1;
	localparam int CTRL_DIR = 2;
	localparam int CTRL_EPN = 3;
	localparam int EPN_W = 3;
	localparam int CTRL_STATE = 8;

	// packet count and slot assignment fields
	localparam int PCOUNT_W = 17;
	localparam int SLOT_MASK = 0;
	localparam int SLOT_BPS = 14;
	localparam int BPS_W = 2;

	// reset values
	localparam logic FLAG_RST = 1'b0;
	localparam logic [EPN_W-1:0] EPN_RST = 3'h0;
	localparam logic [PCOUNT_W-1:0] PCOUNT_RST = 17'h00000;
	localparam logic [SLOTS-1:0] MASK_RST = 14'h0000;
	localparam logic [BPS_W-1:0] BPS_RST = 2'h1;

	// channel engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_MOVE = 4'b0010,
		ST_WSOF = 4'b0100,
		ST_WFRM = 4'b1000
	} ecdma_state_t;

endpackage : ecdma_pkg

// File: src/ecdma_sync.sv
// two-flop synchroniser for codec pins
// assumes inputs are asynchronous to sys_clk; only the second stage is read outside
`timescale 1ns/1ps
module ecdma_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// pins in, synchronised levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : ecdma_sync

// File: verification/ecdma_monitor.sv
// assertion checker for the two-channel dma block, sees top-level ports only
// assumes the bench keeps channel 0 on bulk work unless iso is flagged
`timescale 1ns/1ps
module ecdma_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// buffer manager side
	input wire logic [ecdma_pkg::NCH-1:0] ep_iso,
	input wire logic [ecdma_pkg::NCH-1:0] ep_x_nack,
	input wire logic [ecdma_pkg::NCH-1:0] ep_y_nack,
	input wire logic [ecdma_pkg::NCH-1:0] chan_ep_dir,
	input wire logic [ecdma_pkg::NCH-1:0] nack_clr_x,
	input wire logic [ecdma_pkg::NCH-1:0] nack_clr_y,
	input wire logic chan0_done_irq,
	input wire logic chan1_done_irq,
	// memory strobes
	input wire logic mem_rd,
	input wire logic mem_wr
);
	default clocking mon_cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// completion is an event, a held level would raise it twice
	done0_pulse_a: assert property (chan0_done_irq |=> !chan0_done_irq)
		else $error("channel 0 done held high");
	done1_pulse_a: assert property (chan1_done_irq |=> !chan1_done_irq)
		else $error("channel 1 done held high");
	// a buffer is only released after it was seen full
	clr_x_cause_a: assert property (nack_clr_x[0] |-> $past(ep_x_nack[0]))
		else $error("x buffer cleared while empty");
	clr_y_cause_a: assert property (nack_clr_y[0] |-> $past(ep_y_nack[0]))
		else $error("y buffer cleared while empty");
	clr_single_a: assert property (!(nack_clr_x[0] && nack_clr_y[0]))
		else $error("both buffers released together");
	// bulk in never moves through a channel
	bulk_in_idle_a: assert property ((!ep_iso[0] && chan_ep_dir[0]) |-> !nack_clr_x[0])
		else $error("bulk in buffer drained by channel");
	// one fetch outstanding per channel, so with channel 1 quiet reads never come back to back
	rd_spacing_a: assert property (mem_rd |=> !mem_rd)
		else $error("memory reads back to back");
	mem_excl_a: assert property (mem_rd |-> !mem_wr)
		else $error("memory read and write together");
endmodule : ecdma_monitor

bind ecdma_dma_channels ecdma_monitor u_ecdma_monitor (
	.sys_clk(sys_clk), .reset(reset), .ep_iso(ep_iso), .ep_x_nack(ep_x_nack),
	.ep_y_nack(ep_y_nack), .chan_ep_dir(chan_ep_dir), .nack_clr_x(nack_clr_x),
	.nack_clr_y(nack_clr_y), .chan0_done_irq(chan0_done_irq),
	.chan1_done_irq(chan1_done_irq), .mem_rd(mem_rd), .mem_wr(mem_wr)
);

// File: verification/ecdma_codec_model.sv
// external codec device: makes frame clock and sync, captures slot 0 byte 0
// assumes 16-bit slots, 14 slots a frame, clock stops between frames when idle
`timescale 1ns/1ps
module ecdma_codec_model (
	// frame control
	input wire logic run,
	// codec pins
	output logic codec_clk,
	output logic codec_sync,
	output logic codec_din,
	input wire logic codec_dout,
	input wire logic codec_dout_oe,
	// captured output byte and count of bytes seen
	output logic [7:0] rx_byte,
	output logic [7:0] rx_count
);
	int pos = 0;
	logic [7:0] sh = 8'h00;
	logic got = 1'b0;

	// pins move on the falling edge, dout is sampled on the rise since the block lags it
	initial
	begin
		codec_clk = 1'b0;
		codec_sync = 1'b0;
		codec_din = 1'b0;
		rx_byte = 8'h00;
		rx_count = 8'h00;
		forever
		begin
			#32;
			if (run || pos != 0)
			begin
				codec_clk = ~codec_clk;
				if (codec_clk)
				begin
					if (pos >= 1 && pos <= 8)
						sh = {sh[6:0], codec_dout};
					if (pos == 1)
						got = codec_dout_oe;
					if (pos == 8 && got)
						rx_byte = sh;
					if (pos == 8 && got)
						rx_count = rx_count + 8'h01;
					pos = (pos + 1) % 224;
				end
				else
				begin
					codec_sync = (pos == 0); // sync every frame; oe marks slots with data
					codec_din = ~codec_din; // changes every bit so stale data never matches
				end
			end
		end
	end
endmodule : ecdma_codec_model

// File: verification/ecdma_dma_channels_tb.sv
// bench for the two-channel endpoint to codec dma block
// assumes channel 0 carries all traffic; channel 1 inputs stay quiet
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
	begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module ecdma_dma_channels_tb;
	logic sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, sof = 1'b0;
	logic [5:0] avs_address = 6'h00, chan_ep_num;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [1:0] ep_iso = 2'h0, ep_dbuf = 2'h0, ep_x_nack = 2'h0, ep_y_nack = 2'h0;
	logic [1:0] ep_toggle = 2'h0, chan_ep_dir, nack_clr_x, nack_clr_y;
	logic [21:0] ep_x_base = 22'h000010, ep_y_base = 22'h000030, ep_size = 22'h000040;
	logic [21:0] ep_x_count = 22'h000001, ep_y_count = 22'h000001, ep_ring_ptr = 22'h0;
	logic [21:0] ring_ptr;
	logic avs_waitrequest, chan0_done_irq, chan1_done_irq, mem_rd, mem_wr;
	logic codec_clk, codec_sync, codec_din, codec_dout, codec_dout_oe;
	logic [10:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata = 8'h00, rx_byte, rx_count;
	logic [7:0] mem [0:2047];
	int n_fail = 0, cmp_count = 0;

	ecdma_dma_channels u_ecdma_dma_channels (.sys_clk, .reset, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sof, .ep_iso, .ep_dbuf,
		.ep_x_nack, .ep_y_nack, .ep_toggle, .ep_x_base, .ep_y_base, .ep_size, .ep_x_count,
		.ep_y_count, .ep_ring_ptr, .chan_ep_num, .chan_ep_dir, .nack_clr_x, .nack_clr_y,
		.ring_ptr, .chan0_done_irq, .chan1_done_irq, .mem_addr, .mem_rd, .mem_wr,
		.mem_wdata, .mem_rdata, .codec_clk, .codec_sync, .codec_din, .codec_dout,
		.codec_dout_oe);
	ecdma_codec_model u_ecdma_codec_model (.run(1'b1), .codec_clk, .codec_sync,
		.codec_din, .codec_dout, .codec_dout_oe, .rx_byte, .rx_count);

	// clock
	initial
	begin
		forever #4 sys_clk = ~sys_clk;
	end

	// buffer manager stand-in: memory answers a cycle later, a clear pulse empties a buffer
	always @(posedge sys_clk)
	begin
		if (mem_rd)
			mem_rdata <= mem[mem_addr];
		if (nack_clr_x[0])
			ep_x_nack[0] <= 1'b0;
		if (nack_clr_y[0])
			ep_y_nack[0] <= 1'b0;
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// one avalon transfer held until waitrequest is sampled low, then one idle edge
	task automatic bus_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
		if (n >= 50)
			n_fail++;
		if (n >= 50)
			end_of_test();
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus_xfer

	// fill one buffer, wait for its release and the byte on the codec line
	task automatic drain(input logic y, input logic [7:0] ex, input logic done_ex);
		int n = 0;
		logic got_clr = 1'b0, got_oth = 1'b0, got_done = 1'b0;
		logic [7:0] c0 = rx_count;
		mem[y ? 48 : 16] = ex;
		if (y)
			ep_y_nack[0] <= 1'b1;
		else
			ep_x_nack[0] <= 1'b1;
		while ((!got_clr || rx_count == c0) && n++ < 8000)
		begin
			@(posedge sys_clk);
			got_oth |= !got_clr && (y ? nack_clr_x[0] : nack_clr_y[0]);
			got_clr |= y ? nack_clr_y[0] : nack_clr_x[0];
			got_done |= chan0_done_irq;
		end
		if (n > 8000)
			n_fail++;
		if (n > 8000)
			end_of_test();
		`CHK("nack clear", 1'b1, got_clr)
		`CHK("other buffer first", 1'b0, got_oth)
		`CHK("codec byte", ex, rx_byte)
		`CHK("done irq", done_ex, got_done)
	endtask : drain

	task automatic check_regs;
		bus_xfer(1'b0, 6'h00, 32'h0);
		`CHK("control reset", 32'h00000100, q)
		bus_xfer(1'b0, 6'h08, 32'h0);
		`CHK("slot reset", 32'h00004000, q)
		bus_xfer(1'b1, 6'h08, 32'h00007FFF);
		bus_xfer(1'b0, 6'h08, 32'h0);
		`CHK("slot mask", 32'h00007FFF, q)
		bus_xfer(1'b1, 6'h08, 32'h00004001); // slot 0, one byte per slot
		bus_xfer(1'b1, 6'h04, 32'h00010000);
		bus_xfer(1'b0, 6'h04, 32'h0);
		`CHK("packet count", 32'h00010000, q)
		bus_xfer(1'b0, 6'h10, 32'h0);
		`CHK("unmapped", 32'h0, q)
	endtask : check_regs

	task automatic run_handshake;
		bus_xfer(1'b1, 6'h04, 32'h00000002);
		bus_xfer(1'b1, 6'h00, 32'h0000000B); // device ready, endpoint irq not ours
		`CHK("endpoint number", 3'h1, chan_ep_num[2:0])
		drain(1'b0, 8'hA1, 1'b0);
		bus_xfer(1'b0, 6'h04, 32'h0);
		`CHK("packets left", 32'h00000001, q)
		drain(1'b0, 8'h5E, 1'b1);
		bus_xfer(1'b0, 6'h00, 32'h0);
		`CHK("enable cleared", 1'b0, q[0])
		// nothing to unmask afterwards: the stand-in raises no endpoint irq
	endtask : run_handshake

	// both buffers full with toggle 1 drains y first, then runs without a limit
	task automatic run_direct;
		mem[16] = 8'h3C;
		mem[48] = 8'hC3;
		ep_dbuf <= 2'h1;
		ep_toggle <= 2'h1;
		ep_x_nack <= 2'h1;
		ep_y_nack <= 2'h1;
		bus_xfer(1'b1, 6'h00, 32'h00000009);
		drain(1'b1, 8'hC3, 1'b0);
		drain(1'b0, 8'h3C, 1'b0);
		drain(1'b0, 8'h96, 1'b0);
		bus_xfer(1'b0, 6'h00, 32'h0);
		`CHK("still enabled", 1'b1, q[0])
		bus_xfer(1'b1, 6'h00, 32'h00000008);
	endtask : run_direct

	task automatic run_bulk_in;
		logic seen = 1'b0;
		ep_dbuf <= 2'h0;
		bus_xfer(1'b1, 6'h00, 32'h0000000D);
		`CHK("endpoint direction", 1'b1, chan_ep_dir[0])
		ep_x_nack <= 2'h1;
		repeat (2000)
		begin
			@(posedge sys_clk);
			seen |= mem_rd | nack_clr_x[0];
		end
		`CHK("bulk in idle", 1'b0, seen)
		bus_xfer(1'b1, 6'h00, 32'h00000000);
		ep_x_nack <= 2'h0;
	endtask : run_bulk_in

	// iso out: count at sof is write pointer minus read pointer
	task automatic run_iso_count;
		ep_iso <= 2'h1;
		ep_ring_ptr <= 22'h000005;
		bus_xfer(1'b1, 6'h00, 32'h00000009);
		sof <= 1'b1;
		@(posedge sys_clk);
		sof <= 1'b0;
		repeat (2) @(posedge sys_clk);
		bus_xfer(1'b0, 6'h0C, 32'h0);
		`CHK("frame byte count", 32'h00000005, q)
	endtask : run_iso_count

	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		check_regs();
		run_handshake();
		run_direct();
		run_bulk_in();
		run_iso_count();
		end_of_test();
	end
endmodule : ecdma_dma_channels_tb
